// ---- rtl/pmoc_pkg.sv ----
/*
  Shared constants for the conversion-control command port: command
  codes, field positions, margin codes, host register map and timing.
  Assumes a single 20 MHz clock shared by both ends of the link.
*/
package pmoc_pkg;

  // ----------------------------------------------------------------
  // Command codes and block layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CONV_CTRL = 8'h01;
  localparam logic [7:0] CMD_ALERT_STAT = 8'h7E;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h7F;
  localparam int BLOCK_BYTES = 4;
  localparam int BYTE_W = 8;
  localparam logic [2:0] CNT_ONE = 3'h1;

  // ----------------------------------------------------------------
  // Conversion-control byte fields
  // ----------------------------------------------------------------
  localparam int ON_OFF_BIT = 7;
  localparam int SOFT_OFF_BIT = 6;
  localparam int MARGIN_HI = 5;
  localparam int MARGIN_LO = 2;
  localparam logic [7:0] CONV_RESET = 8'h00;
  localparam logic [7:0] CONV_WR_MASK = 8'hFE;

  // Margin codes
  localparam logic [3:0] MRG_OFF0 = 4'h0;
  localparam logic [3:0] MRG_OFF1 = 4'h1;
  localparam logic [3:0] MRG_OFF2 = 4'h2;
  localparam logic [3:0] MRG_LOW_IGN = 4'h5;
  localparam logic [3:0] MRG_LOW_ACT = 4'h6;
  localparam logic [3:0] MRG_HIGH_IGN = 4'h9;
  localparam logic [3:0] MRG_HIGH_ACT = 4'hA;

  // Output target selection
  localparam logic [1:0] TGT_NOMINAL = 2'h0;
  localparam logic [1:0] TGT_LOW = 2'h1;
  localparam logic [1:0] TGT_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // Device alert status bits
  // ----------------------------------------------------------------
  localparam int ST_BAD_CMD = 0;
  localparam int ST_BAD_DATA = 1;
  localparam int ST_STOPPED = 2;
  localparam logic [7:0] ALERT_MASK_RESET = 8'h07;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h08;
  localparam logic [7:0] HREG_STAT = 8'h0C;
  localparam logic [7:0] HREG_IRQ_STAT = 8'h10;
  localparam logic [7:0] HREG_IRQ_MASK = 8'h14;
  localparam int HCMD_CNT_LO = 8;
  localparam int HCMD_READ_BIT = 11;
  localparam int HIRQ_DONE = 0;
  localparam int HIRQ_NAK = 1;
  localparam int HIRQ_ALERT = 2;
  localparam logic [2:0] HIRQ_MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TOFF_DELAY_NS = 1000;
  localparam int TOFF_CYC = (TOFF_DELAY_NS + CLK_PERIOD_NS - 1) /
                            CLK_PERIOD_NS;

endpackage : pmoc_pkg

// ---- rtl/pmoc_link_if.sv ----
/*
  Byte-level command link between the host controller and the device.
  Assumes both ends sit on the same clock; every signal is a flop output.
*/
`timescale 1ns/1ps
interface pmoc_link_if (
  input wire logic clock_i,
  input wire logic resetn_i
);
  // Host to device
  logic h_start;
  logic h_read;
  logic h_valid;
  logic h_rdreq;
  logic h_stop;
  logic [7:0] h_byte;
  // Device to host
  logic d_valid;
  logic d_nak;
  logic [7:0] d_byte;
  logic d_alert;

  modport dev_mp (
    input h_start, h_read, h_valid, h_rdreq, h_stop, h_byte,
    output d_valid, d_nak, d_byte, d_alert
  );
  modport host_mp (
    output h_start, h_read, h_valid, h_rdreq, h_stop, h_byte,
    input d_valid, d_nak, d_byte, d_alert
  );
endinterface : pmoc_link_if

// ---- rtl/pmoc_device.sv ----
/*
  Device end: holds the conversion-control byte, answers byte and block
  transactions, drives the conversion sequencer and the alert line.
  Assumes the host keeps the link order start, data, stop; enable pin
  and ramp-done come from outside the clock domain.
*/
`timescale 1ns/1ps
module pmoc_device #(
  parameter int TOFF_CYCLES = pmoc_pkg::TOFF_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Link
  pmoc_link_if.dev_mp link,
  // Enable-source configuration
  input wire logic src_cmd_i,
  input wire logic src_pin_i,
  input wire logic enable_pin_i,
  // Power stage
  input wire logic ramp_done_i,
  output logic convert_o,
  output logic ramp_down_o,
  output logic stage_hiz_o,
  output logic [1:0] target_sel_o,
  output logic fault_ignore_o
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMOC_OFF = 2'h0,
    PMOC_RUN = 2'h1,
    PMOC_DELAY = 2'h3,
    PMOC_RAMP = 2'h2
  } pmoc_seq_e;

  // Margin decode: {valid, target[1:0], ignore faults}
  function automatic logic [3:0] margin_dec(input logic [3:0] code);
    case (code)
      pmoc_pkg::MRG_OFF0, pmoc_pkg::MRG_OFF1, pmoc_pkg::MRG_OFF2:
        margin_dec = {1'b1, pmoc_pkg::TGT_NOMINAL, 1'b0};
      pmoc_pkg::MRG_LOW_IGN: margin_dec = {1'b1, pmoc_pkg::TGT_LOW, 1'b1};
      pmoc_pkg::MRG_LOW_ACT: margin_dec = {1'b1, pmoc_pkg::TGT_LOW, 1'b0};
      pmoc_pkg::MRG_HIGH_IGN: margin_dec = {1'b1, pmoc_pkg::TGT_HIGH, 1'b1};
      pmoc_pkg::MRG_HIGH_ACT: margin_dec = {1'b1, pmoc_pkg::TGT_HIGH, 1'b0};
      default: margin_dec = {1'b0, pmoc_pkg::TGT_NOMINAL, 1'b0};
    endcase
  endfunction : margin_dec

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic en_meta_q, en_sync_q, done_meta_q, done_sync_q;

  // Two flops each; the first stage feeds only the second
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
      done_meta_q <= 1'b0;
      done_sync_q <= 1'b0;
    end else begin
      en_meta_q <= enable_pin_i;
      en_sync_q <= en_meta_q;
      done_meta_q <= ramp_done_i;
      done_sync_q <= done_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Transaction capture
  // ----------------------------------------------------------------
  logic [7:0] code_q;
  logic rd_q;
  logic [2:0] cnt_q;
  logic [31:0] data_q;

  // Data bytes land lowest first, each in the next higher lane
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      code_q <= '0;
      rd_q <= 1'b0;
      cnt_q <= '0;
      data_q <= '0;
    end else if (link.h_start) begin
      code_q <= link.h_byte;
      rd_q <= link.h_read;
      cnt_q <= '0;
      data_q <= '0;
    end else if (link.h_valid || link.h_rdreq) begin
      if (link.h_valid && cnt_q < 3'(pmoc_pkg::BLOCK_BYTES)) begin
        data_q[{cnt_q[1:0], 3'b000} +: pmoc_pkg::BYTE_W] <= link.h_byte;
      end
      if (cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1; // saturates so odd extra bytes still count
      end
    end
  end

  // ----------------------------------------------------------------
  // Write completion and validity
  // ----------------------------------------------------------------
  logic wr_end, is_conv, wr_ok, bad_cmd_wr, bad_data_wr;
  logic [3:0] new_mrg;

  assign wr_end = link.h_stop && !rd_q;
  assign is_conv = (code_q == pmoc_pkg::CMD_CONV_CTRL);
  assign new_mrg = margin_dec(
    data_q[pmoc_pkg::MARGIN_HI:pmoc_pkg::MARGIN_LO]);
  // Only one data byte with a listed margin code is accepted
  assign wr_ok = is_conv && (cnt_q == pmoc_pkg::CNT_ONE) && new_mrg[3];
  assign bad_data_wr = wr_end && is_conv && !wr_ok;
  assign bad_cmd_wr = wr_end && !is_conv &&
    !((code_q == pmoc_pkg::CMD_ALERT_MASK) &&
      (cnt_q == pmoc_pkg::CNT_ONE));

  // ----------------------------------------------------------------
  // Conversion-control and alert mask registers
  // ----------------------------------------------------------------
  logic [7:0] conv_q, mask_q;

  // Volatile; a good write takes effect on the next edge
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_q <= pmoc_pkg::CONV_RESET;
    end else if (wr_end && wr_ok) begin
      conv_q <= data_q[7:0] & pmoc_pkg::CONV_WR_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_q <= pmoc_pkg::ALERT_MASK_RESET;
    end else if (wr_end && code_q == pmoc_pkg::CMD_ALERT_MASK &&
                 cnt_q == pmoc_pkg::CNT_ONE) begin
      mask_q <= data_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  logic rd_hit, rd_stat;
  logic [7:0] stat_q;

  // Only the first data byte of a read exists; later ones are refused
  assign rd_hit = link.h_rdreq && (cnt_q == '0) &&
    (is_conv || code_q == pmoc_pkg::CMD_ALERT_STAT ||
     code_q == pmoc_pkg::CMD_ALERT_MASK);
  assign rd_stat = rd_hit && (code_q == pmoc_pkg::CMD_ALERT_STAT);

  // Answer stands for the one cycle after the request
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.d_valid <= 1'b0;
      link.d_nak <= 1'b0;
      link.d_byte <= '0;
    end else begin
      link.d_valid <= rd_hit;
      link.d_nak <= (link.h_rdreq && !rd_hit) || bad_cmd_wr ||
                    bad_data_wr;
      if (!rd_hit) begin
        link.d_byte <= '0;
      end else if (is_conv) begin
        link.d_byte <= conv_q;
      end else if (rd_stat) begin
        link.d_byte <= stat_q;
      end else begin
        link.d_byte <= mask_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  pmoc_seq_e seq_q, seq_d;
  logic want_on;
  logic [15:0] dly_q;
  logic stop_evt;

  // Each enabled source must agree before conversion may run
  assign want_on = (!src_cmd_i || conv_q[pmoc_pkg::ON_OFF_BIT]) &&
                   (!src_pin_i || en_sync_q);

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      PMOC_OFF: if (want_on) seq_d = PMOC_RUN;
      PMOC_RUN: begin
        if (!want_on) begin
          seq_d = conv_q[pmoc_pkg::SOFT_OFF_BIT] ? PMOC_DELAY
                                                : PMOC_OFF;
        end
      end
      PMOC_DELAY: if (dly_q == '0) seq_d = PMOC_RAMP;
      PMOC_RAMP: if (done_sync_q) seq_d = PMOC_OFF;
      default: seq_d = PMOC_OFF;
    endcase
  end

  assign stop_evt = (seq_q != PMOC_OFF) && (seq_d == PMOC_OFF);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_q <= PMOC_OFF;
    end else begin
      seq_q <= seq_d;
    end
  end

  // Delay loaded on entry; a soft stop always runs to the end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dly_q <= '0;
    end else if (seq_q == PMOC_RUN) begin
      dly_q <= 16'(TOFF_CYCLES - 1);
    end else if (seq_q == PMOC_DELAY && dly_q != '0) begin
      dly_q <= dly_q - 16'h1;
    end
  end

  // Live margin field decoded once for both outputs
  logic [3:0] cur_mrg;

  assign cur_mrg = margin_dec(
    conv_q[pmoc_pkg::MARGIN_HI:pmoc_pkg::MARGIN_LO]);

  // Outputs follow the next state and the live margin field
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      convert_o <= 1'b0;
      ramp_down_o <= 1'b0;
      stage_hiz_o <= 1'b1;
      target_sel_o <= pmoc_pkg::TGT_NOMINAL;
      fault_ignore_o <= 1'b0;
    end else begin
      convert_o <= (seq_d == PMOC_RUN) || (seq_d == PMOC_DELAY);
      ramp_down_o <= (seq_d == PMOC_RAMP);
      stage_hiz_o <= (seq_d == PMOC_OFF);
      target_sel_o <= cur_mrg[2:1];
      fault_ignore_o <= cur_mrg[0];
    end
  end

  // ----------------------------------------------------------------
  // Alert status: sticky, cleared by reading it, set wins
  // ----------------------------------------------------------------
  logic [7:0] stat_set;

  assign stat_set = {5'h00, stop_evt, bad_data_wr, bad_cmd_wr};

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= '0;
    end else if (rd_stat) begin
      stat_q <= stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.d_alert <= 1'b0;
    end else begin
      link.d_alert <= |((stat_q | stat_set) & mask_q);
    end
  end

endmodule : pmoc_device

// ---- rtl/pmoc_host.sv ----
/*
  Host end: takes orders over a plain register port and runs byte and
  block transactions on the link, low byte first.
  Assumes the device answers a read request in the next cycle.
*/
`timescale 1ns/1ps
module pmoc_host (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  // Link
  pmoc_link_if.host_mp link
);

  // ----------------------------------------------------------------
  // Orders
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMOC_IDLE = 2'h0,
    PMOC_START = 2'h1,
    PMOC_DATA = 2'h3,
    PMOC_STOP = 2'h2
  } pmoc_hst_e;

  pmoc_hst_e st_q;
  logic [7:0] code_q;
  logic [2:0] cnt_q, idx_q;
  logic rd_q, wait_q;
  logic [31:0] wdat_q, rdat_q;
  logic [2:0] irq_st_q, irq_mask_q, irq_set;
  logic go;

  assign go = we_i && addr_i == pmoc_pkg::HREG_CMD && st_q == PMOC_IDLE;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      code_q <= '0;
      cnt_q <= '0;
      rd_q <= 1'b0;
    end else if (go) begin
      code_q <= wdata_i[7:0];
      cnt_q <= wdata_i[pmoc_pkg::HCMD_CNT_LO +: 3];
      rd_q <= wdata_i[pmoc_pkg::HCMD_READ_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdat_q <= '0;
    end else if (we_i && addr_i == pmoc_pkg::HREG_WDATA) begin
      wdat_q <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= PMOC_IDLE;
      idx_q <= '0;
      wait_q <= 1'b0;
      rdat_q <= '0;
      link.h_start <= 1'b0;
      link.h_read <= 1'b0;
      link.h_valid <= 1'b0;
      link.h_rdreq <= 1'b0;
      link.h_stop <= 1'b0;
      link.h_byte <= '0;
    end else begin
      link.h_start <= 1'b0;
      link.h_valid <= 1'b0;
      link.h_rdreq <= 1'b0;
      link.h_stop <= 1'b0;
      case (st_q)
        PMOC_IDLE: if (go) st_q <= PMOC_START;
        PMOC_START: begin
          link.h_start <= 1'b1;
          link.h_read <= rd_q;
          link.h_byte <= code_q;
          idx_q <= '0;
          wait_q <= 1'b0;
          if (rd_q) rdat_q <= '0;
          st_q <= PMOC_DATA;
        end
        PMOC_DATA: begin
          if (idx_q >= cnt_q || idx_q >= 3'(pmoc_pkg::BLOCK_BYTES)) begin
            if (!wait_q) st_q <= PMOC_STOP;
          end else if (rd_q && !wait_q) begin
            link.h_rdreq <= 1'b1;
            wait_q <= 1'b1;
          end else if (!rd_q) begin
            link.h_valid <= 1'b1;
            link.h_byte <= wdat_q[{idx_q[1:0], 3'b000} +: 8];
            idx_q <= idx_q + 3'h1;
          end
          // Answer cycle after a read request
          if (wait_q && !link.h_rdreq) begin
            wait_q <= 1'b0;
            idx_q <= idx_q + 3'h1;
            if (link.d_valid) begin
              rdat_q[{idx_q[1:0], 3'b000} +: 8] <= link.d_byte;
            end
          end
        end
        PMOC_STOP: begin
          link.h_stop <= 1'b1;
          st_q <= PMOC_IDLE;
        end
        default: st_q <= PMOC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky, read clears, set wins
  // ----------------------------------------------------------------
  assign irq_set = {link.d_alert, link.d_nak, st_q == PMOC_STOP};

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_st_q <= '0;
      irq_mask_q <= pmoc_pkg::HIRQ_MASK_RESET;
      irq_o <= 1'b0;
    end else begin
      if (re_i && addr_i == pmoc_pkg::HREG_IRQ_STAT) begin
        irq_st_q <= irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      if (we_i && addr_i == pmoc_pkg::HREG_IRQ_MASK) begin
        irq_mask_q <= wdata_i[2:0];
      end
      irq_o <= |(irq_st_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe; unmapped reads give zero
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      case (addr_i)
        pmoc_pkg::HREG_CMD: rdata_o <= {20'h00000, rd_q, cnt_q, code_q};
        pmoc_pkg::HREG_WDATA: rdata_o <= wdat_q;
        pmoc_pkg::HREG_RDATA: rdata_o <= rdat_q;
        pmoc_pkg::HREG_STAT: rdata_o <= {31'h0, st_q != PMOC_IDLE};
        pmoc_pkg::HREG_IRQ_STAT: rdata_o <= {29'h0, irq_st_q};
        pmoc_pkg::HREG_IRQ_MASK: rdata_o <= {29'h0, irq_mask_q};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

endmodule : pmoc_host

// ---- tb/pmoc_link_sva.sv ----
/*
  Checker for the link between host and device ends.
  Assumes one clock; sees only the interface signals.
*/
`timescale 1ns/1ps
module pmoc_link_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Host to device
  input wire logic h_start,
  input wire logic h_read,
  input wire logic h_valid,
  input wire logic h_rdreq,
  input wire logic h_stop,
  input wire logic [7:0] h_byte,
  // Device to host
  input wire logic d_valid,
  input wire logic d_nak,
  input wire logic [7:0] d_byte,
  input wire logic d_alert
);
  default clocking dck @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // ------------------------------------------------------------
  // Transaction tracking
  // ------------------------------------------------------------
  logic [7:0] cmd_q, last_q, val_q;
  logic [2:0] cnt_q, rdn_q;
  logic rd_q, good_w, wr01_w;

  // Code, direction and byte counts of the open transaction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_q <= 8'h00;
      rd_q <= 1'b0;
      cnt_q <= 3'h0;
      rdn_q <= 3'h0;
      last_q <= 8'h00;
    end else if (h_start) begin
      cmd_q <= h_byte;
      rd_q <= h_read;
      cnt_q <= 3'h0;
      rdn_q <= 3'h0;
    end else begin
      if (h_valid && cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1;
        last_q <= h_byte;
      end
      if (h_rdreq && rdn_q != 3'h7) begin
        rdn_q <= rdn_q + 3'h1;
      end
    end
  end

  // Only listed margin codes may be stored
  assign good_w = last_q[5:2] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6,
                                      4'h9, 4'hA};
  assign wr01_w = h_stop && !rd_q && cmd_q == 8'h01;

  // Expected stored byte; bit 0 never sticks
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      val_q <= 8'h00;
    end else if (wr01_w && cnt_q == 3'h1 && good_w) begin
      val_q <= last_q & 8'hFE;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  rd_answer_a: assert property (h_rdreq |=> d_valid != d_nak)
    else $error("read request not answered exactly once");
  rd_cause_a: assert property (d_valid |-> $past(h_rdreq))
    else $error("read byte without request");
  rd_value_a: assert property (d_valid && cmd_q == 8'h01
    |-> d_byte == val_q) else $error("read byte not last stored value");
  byte_idle_a: assert property (!d_valid |-> d_byte == 8'h00)
    else $error("read byte line not idle");
  second_rd_a: assert property (h_rdreq && rdn_q != 3'h0
    |=> d_nak && !d_valid) else $error("extra read byte not refused");
  bad_len_a: assert property (wr01_w && cnt_q != 3'h1 |=> d_nak)
    else $error("multi byte write not refused");
  bad_code_a: assert property (wr01_w && cnt_q == 3'h1 && !good_w
    |=> d_nak ##[1:2] d_alert) else $error("bad margin not flagged");
  good_wr_a: assert property (wr01_w && cnt_q == 3'h1 && good_w
    |=> !d_nak) else $error("listed margin code refused");
  nak_cause_a: assert property (d_nak
    |-> $past(h_rdreq) || $past(h_stop)) else $error("stray refusal");
endmodule : pmoc_link_sva

// ---- tb/pmbus_operation_command_port_tb.sv ----
/*
  Bench for the command port: host and device ends joined by the link,
  driven through the host register port.
  Assumes one 20 MHz clock and the link checker beside the interface.
*/
`timescale 1ns/1ps
module pmbus_operation_command_port_tb;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clock_i, resetn_i, we_i, re_i, irq_o;
  logic src_cmd_i, src_pin_i, enable_pin_i, ramp_done_i;
  logic convert_o, ramp_down_o, stage_hiz_o, fault_ignore_o;
  logic [1:0] target_sel_o;
  logic [7:0] addr_i;
  logic [7:0] bq[$];
  logic [31:0] wdata_i, rdata_o, st, rv;
  int error_cnt, n_compared, cyc;
  // Byte written, byte read back, target, fault ignore
  logic [23:0] rows [7] = '{24'h808000, 24'h858400, 24'h8A8A00,
    24'h949411, 24'hD8D810, 24'hA4A421, 24'hABAA20};

  pmoc_link_if pmoc_link_if_inst (.clock_i(clock_i),
    .resetn_i(resetn_i));
  pmoc_device #(.TOFF_CYCLES(4)) pmoc_device_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .link(pmoc_link_if_inst),
    .src_cmd_i(src_cmd_i), .src_pin_i(src_pin_i),
    .enable_pin_i(enable_pin_i), .ramp_done_i(ramp_done_i),
    .convert_o(convert_o), .ramp_down_o(ramp_down_o),
    .stage_hiz_o(stage_hiz_o), .target_sel_o(target_sel_o),
    .fault_ignore_o(fault_ignore_o));
  pmoc_host pmoc_host_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .link(pmoc_link_if_inst));
  pmoc_link_sva pmoc_link_sva_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .h_start(pmoc_link_if_inst.h_start),
    .h_read(pmoc_link_if_inst.h_read),
    .h_valid(pmoc_link_if_inst.h_valid),
    .h_rdreq(pmoc_link_if_inst.h_rdreq),
    .h_stop(pmoc_link_if_inst.h_stop),
    .h_byte(pmoc_link_if_inst.h_byte),
    .d_valid(pmoc_link_if_inst.d_valid),
    .d_nak(pmoc_link_if_inst.d_nak),
    .d_byte(pmoc_link_if_inst.d_byte),
    .d_alert(pmoc_link_if_inst.d_alert));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One idle edge first, so a strobe is never lowered and raised at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clock_i);
    we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clock_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  // Runs one link transaction and waits, bounded, for idle
  task automatic xfer(input logic r, input logic [2:0] n,
      input logic [7:0] c, input logic [31:0] d);
    logic [31:0] v;
    wr(pmoc_pkg::HREG_WDATA, d);
    wr(pmoc_pkg::HREG_CMD, {20'h0, r, n, c});
    v = 32'h1;
    for (int i = 0; i < 40 && v[0] === 1'b1; i++) rd(pmoc_pkg::HREG_STAT, v);
    chk("busy", 32'h0, 32'(v[0]));
    repeat (3) @(posedge clock_i);
    #1;
    rv = 32'h0;
    if (r) rd(pmoc_pkg::HREG_RDATA, rv);
  endtask : xfer

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // Clock, watchdog, link monitor and sequence
  // ------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Run needs about 470 cycles; the ceiling leaves ample margin
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Mid-cycle sampling of write bytes on the link
  always @(negedge clock_i) begin
    if (pmoc_link_if_inst.h_valid) bq.push_back(pmoc_link_if_inst.h_byte);
  end

  initial begin
    {resetn_i, we_i, re_i, src_pin_i, ramp_done_i} = 5'h00;
    {src_cmd_i, enable_pin_i} = 2'h3;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    {error_cnt, n_compared} = '0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    #1;
    chk("hiz", 32'h1, 32'(stage_hiz_o));
    chk("irq", 32'h0, 32'(irq_o));
    rd(8'h20, rv);
    chk("unmapped", 32'h0, rv);
    rd(pmoc_pkg::HREG_IRQ_MASK, rv);
    chk("mask", 32'h0, rv);
    xfer(1'b1, 3'h1, 8'h01, 32'h0);
    chk("op reset", 32'h0, rv);
    wr(pmoc_pkg::HREG_IRQ_MASK, 32'h7);
    foreach (rows[k]) begin
      xfer(1'b0, 3'h1, 8'h01, 32'(rows[k][23:16]));
      chk("irq", 32'h1, 32'(irq_o));
      rd(pmoc_pkg::HREG_IRQ_STAT, st);
      chk("done", 32'h1, 32'(st[0]));
      xfer(1'b1, 3'h1, 8'h01, 32'h0);
      chk("op", 32'(rows[k][15:8]), rv);
      chk("target", 32'(rows[k][5:4]), 32'(target_sel_o));
      chk("ignore", 32'(rows[k][0]), 32'(fault_ignore_o));
      chk("on", 32'h1, 32'(convert_o));
      rd(pmoc_pkg::HREG_IRQ_STAT, st);
    end
    // Interrupt cleared, then masked out
    @(posedge clock_i);
    #1;
    chk("irq clr", 32'h0, 32'(irq_o));
    wr(pmoc_pkg::HREG_IRQ_MASK, 32'h0);
    xfer(1'b0, 3'h1, 8'h01, 32'hAB);
    chk("irq mask", 32'h0, 32'(irq_o));
    rd(pmoc_pkg::HREG_IRQ_STAT, st);
    chk("done", 32'h1, 32'(st[0]));
    // Enable pin as a second source
    @(posedge clock_i);
    src_pin_i <= 1'b1;
    enable_pin_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
    chk("pin off", 32'h0, 32'(convert_o));
    @(posedge clock_i);
    enable_pin_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    chk("pin on", 32'h1, 32'(convert_o));
    @(posedge clock_i);
    src_pin_i <= 1'b0;
    // Immediate off, then soft off with ramp
    xfer(1'b0, 3'h1, 8'h01, 32'h00);
    chk("off", 32'h2, 32'({stage_hiz_o, convert_o}));
    xfer(1'b0, 3'h1, 8'h01, 32'hC0);
    chk("run", 32'h1, 32'({stage_hiz_o, convert_o}));
    xfer(1'b0, 3'h1, 8'h01, 32'h40);
    repeat (6) @(posedge clock_i);
    #1;
    chk("ramp", 32'h2, 32'({stage_hiz_o, ramp_down_o, 1'b0}));
    @(posedge clock_i);
    ramp_done_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    chk("soft", 32'h4, 32'({stage_hiz_o, ramp_down_o, convert_o}));
    @(posedge clock_i);
    ramp_done_i <= 1'b0;
    // Refused writes and reads
    xfer(1'b0, 3'h2, 8'h01, 32'h8080);
    rd(pmoc_pkg::HREG_IRQ_STAT, st);
    chk("len nak", 32'h1, 32'(st[1]));
    xfer(1'b0, 3'h1, 8'h01, 32'h8C);
    rd(pmoc_pkg::HREG_IRQ_STAT, st);
    chk("code nak", 32'h1, 32'(st[1]));
    xfer(1'b1, 3'h1, 8'h01, 32'h0);
    chk("op kept", 32'h40, rv);
    xfer(1'b1, 3'h1, 8'h7E, 32'h0);
    chk("bad data", 32'h1, 32'(rv[1]));
    xfer(1'b1, 3'h2, 8'h01, 32'h0);
    rd(pmoc_pkg::HREG_IRQ_STAT, st);
    chk("rd nak", 32'h1, 32'(st[1]));
    // Block bytes leave lowest first
    bq.delete();
    xfer(1'b0, 3'h4, 8'h30, 32'h44332211);
    chk("blk n", 32'h4, 32'(bq.size()));
    chk("blk", 32'h44332211, {bq[3], bq[2], bq[1], bq[0]});
    // Reset in mid-run drops the stored byte
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    xfer(1'b1, 3'h1, 8'h01, 32'h0);
    chk("op rst", 32'h0, rv);
    end_sim();
  end
endmodule : pmbus_operation_command_port_tb
